// [rtl/cwd_config_decode.sv]
`timescale 1ns/100ps
// Contract
// - Codes 0..18 give ratio two to code+5.
// - Codes 19..30 give 1:32, no software control.
// - Code 31 acts as 11, software selects.
// - Low-voltage bit one allows low-voltage entry.
// - Zero write to low-voltage bit ignored during a low-voltage session.
// - Each region protect bit acts independently; storage protection also needs the store-enable bit clear.
// - Boot size zero, 512 or 1024 words.
module cwd_config_decode
  import cwd_pkg::*;
(
  // Clock and reset.
  input wire logic clk_in,
  input wire logic reset_in,
  // Non-volatile words sampled at start-up.
  input wire logic [13:0] nv_wdt_word_in,
  input wire logic [13:0] nv_mem_word_in,
  // Programming session status.
  input wire logic prog_active_in,
  input wire logic lv_session_in,
  // Wishbone slave.
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [7:0] wb_adr_in,
  input wire logic [3:0] wb_sel_in,
  input wire logic [31:0] wb_dat_in,
  output logic [31:0] wb_dat_out,
  output logic wb_ack_out,
  // Watchdog prescaler.
  output logic [4:0] wdt_prescale_exp_out,
  output logic wdt_runtime_allowed_out,
  // Programming entry.
  output logic lv_entry_allowed_out,
  output logic hv_required_out,
  // Self-write protection, high means protected.
  output logic app_protect_out,
  output logic storage_protect_out,
  output logic boot_protect_out,
  output logic cfg_protect_out,
  output logic [10:0] boot_size_out
);

  typedef struct packed {
    logic loaded;
    logic [13:0] wdt_word;
    logic [13:0] mem_word;
    logic [4:0] runtime;
    logic ack;
    logic [31:0] rdata;
    logic [4:0] exp;
    logic rt_ok;
    logic lv_prog;
    logic [3:0] prot;
    logic [10:0] bsize;
  } cwd_state_t;

  cwd_state_t state_q;
  cwd_state_t state_d;
  logic [4:0] cfg_exp;
  logic cfg_rt_ok;
  logic [4:0] run_exp;
  logic bus_req;
  logic wr_mem;

  // Merges the two low byte lanes of a write into a 14-bit word.
  function automatic logic [13:0] cwd_merge(input logic [13:0] old_w,
                                            input logic [31:0] dat,
                                            input logic [3:0] sel);
    logic [13:0] res;
    res = old_w;
    if (sel[0]) begin
      res[7:0] = dat[7:0];
    end
    if (sel[1]) begin
      res[13:8] = dat[13:8];
    end
    return res;
  endfunction

  // The same table serves the fused code and the software code.
  cwd_period_decode u_cfg_dec (
    .code_in(state_q.wdt_word[CWD_PSEL_LSB +: 5]),
    .exp_out(cfg_exp),
    .runtime_ok_out(cfg_rt_ok)
  );

  cwd_period_decode u_run_dec (
    .code_in(state_q.runtime),
    .exp_out(run_exp),
    .runtime_ok_out()
  );

  assign bus_req = wb_cyc_in && wb_stb_in && !state_q.ack;
  assign wr_mem = bus_req && wb_we_in && prog_active_in && (wb_adr_in == CWD_MEM_WORD_OFS);

  // Next state: start-up load, bus access and the registered decodes.
  always_comb begin
    logic [13:0] mw;
    mw = 14'h0000;
    state_d = state_q;
    state_d.ack = bus_req;
    if (!state_q.loaded) begin
      // The fused words load on the first edge after reset, so reset holds only constants.
      // A bus access in this edge is acked but dropped; software must wait one more cycle.
      state_d.loaded = 1'b1;
      state_d.wdt_word = nv_wdt_word_in | CWD_WDT_ONES;
      state_d.mem_word = nv_mem_word_in | CWD_MEM_ONES;
    end else if (bus_req) begin
      unique case (wb_adr_in)
        CWD_WDT_WORD_OFS: begin
          state_d.rdata = {18'h00000, state_q.wdt_word};
          if (wb_we_in && prog_active_in) begin
            state_d.wdt_word = cwd_merge(state_q.wdt_word, wb_dat_in, wb_sel_in) | CWD_WDT_ONES;
          end
        end
        CWD_MEM_WORD_OFS: begin
          state_d.rdata = {18'h00000, state_q.mem_word};
          mw = cwd_merge(state_q.mem_word, wb_dat_in, wb_sel_in) | CWD_MEM_ONES;
          if (lv_session_in) begin
            mw[CWD_LV_PROG_BIT] = state_q.mem_word[CWD_LV_PROG_BIT] | mw[CWD_LV_PROG_BIT];
          end
          if (wr_mem) begin
            state_d.mem_word = mw;
          end
        end
        CWD_RUNTIME_OFS: begin
          state_d.rdata = {27'h0000000, state_q.runtime};
          // Software only steers the period when the fused code hands it over.
          if (wb_we_in && wb_sel_in[0] && cfg_rt_ok) begin
            state_d.runtime = wb_dat_in[4:0];
          end
        end
        CWD_STATUS_OFS: begin
          state_d.rdata = {15'h0000, state_q.bsize, state_q.rt_ok, state_q.exp};
        end
        default: begin
          state_d.rdata = 32'h00000000;
        end
      endcase
    end
    // Effective prescale follows the software code only under the default fused code.
    state_d.exp = cfg_rt_ok ? run_exp : cfg_exp;
    state_d.rt_ok = cfg_rt_ok;
    state_d.lv_prog = state_q.mem_word[CWD_LV_PROG_BIT];
    state_d.prot[0] = !state_q.mem_word[CWD_WRAPP_BIT];
    state_d.prot[1] = !state_q.mem_word[CWD_WRSAF_BIT]
      && !state_q.mem_word[CWD_STORE_EN_BIT];
    state_d.prot[2] = !state_q.mem_word[CWD_WRBOOT_BIT];
    state_d.prot[3] = !state_q.mem_word[CWD_WRCFG_BIT];
    if (state_q.mem_word[CWD_BOOT_EN_BIT]) begin
      state_d.bsize = 11'h000;
    end else if (state_q.mem_word[CWD_BOOT_SIZE_LSB +: 3] == CWD_BOOT_CODE_SMALL) begin
      state_d.bsize = CWD_BOOT_SMALL;
    end else begin
      // Larger selections are clamped to half of program memory.
      state_d.bsize = CWD_BOOT_HALF;
    end
  end

  // Single state register.
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      state_q <= '{loaded: 1'b0, wdt_word: CWD_WORD_ERASED, mem_word: CWD_WORD_ERASED,
                   runtime: CWD_RUNTIME_RESET, ack: 1'b0, rdata: 32'h00000000,
                   exp: CWD_EXP_OFFSET, rt_ok: 1'b0, lv_prog: 1'b1, prot: 4'h0,
                   bsize: 11'h000};
    end else begin
      state_q <= state_d;
    end
  end

  // Outputs straight from the state register.
  assign wb_ack_out = state_q.ack;
  assign wb_dat_out = state_q.rdata;
  assign wdt_prescale_exp_out = state_q.exp;
  assign wdt_runtime_allowed_out = state_q.rt_ok;
  assign lv_entry_allowed_out = state_q.lv_prog;
  assign hv_required_out = !state_q.lv_prog;
  assign app_protect_out = state_q.prot[0];
  assign storage_protect_out = state_q.prot[1];
  assign boot_protect_out = state_q.prot[2];
  assign cfg_protect_out = state_q.prot[3];
  assign boot_size_out = state_q.bsize;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (reset_in);

  logic [4:0] code_w;
  assign code_w = state_q.wdt_word[4:0];

  linear_ratio_a: assert property ($past(code_w) <= 5'h12 && !$past(reset_in)
    |-> wdt_prescale_exp_out == $past(code_w) + 5'h05)
    else $error("linear period code decoded wrong");
  high_codes_a: assert property ($past(code_w) > 5'h12 && $past(code_w) < 5'h1F
    && !$past(reset_in) |-> wdt_prescale_exp_out == 5'h05 && !wdt_runtime_allowed_out)
    else $error("high period code not at shortest ratio");
  default_code_a: assert property ($past(code_w) == 5'h1F && !$past(reset_in)
    |-> wdt_runtime_allowed_out)
    else $error("default code does not hand over to software");
  runtime_lock_a: assert property (!cfg_rt_ok |=> $stable(state_q.runtime))
    else $error("software period changed while locked");
  lv_entry_a: assert property (##1 lv_entry_allowed_out == $past(state_q.mem_word[13])
    && hv_required_out == !lv_entry_allowed_out)
    else $error("programming entry does not follow its bit");
  lv_hold_a: assert property (wr_mem && lv_session_in && state_q.mem_word[13]
    |=> state_q.mem_word[13])
    else $error("low-voltage bit cleared during session");
  storage_protect_a: assert property (##1
    storage_protect_out == ($past(!state_q.mem_word[11]) && $past(!state_q.mem_word[4])))
    else $error("storage protection wrong");
  region_protect_a: assert property (##1
    app_protect_out == $past(!state_q.mem_word[7])
    && boot_protect_out == $past(!state_q.mem_word[8])
    && cfg_protect_out == $past(!state_q.mem_word[9]))
    else $error("region protection wrong");
  boot_size_a: assert property ($past(state_q.mem_word[3]) && !$past(reset_in)
    |-> boot_size_out == 11'h000)
    else $error("boot size not zero when disabled");
  bus_ack_a: assert property (wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out ##1 !wb_ack_out)
    else $error("bus ack not a single cycle");

  default_mode_c: cover property (wdt_runtime_allowed_out && wdt_prescale_exp_out != 5'h10);
  lv_block_c: cover property (wr_mem && lv_session_in && !wb_dat_in[13]);
  boot_small_c: cover property (boot_size_out == 11'h200);

endmodule

// [rtl/cwd_period_decode.sv]
`timescale 1ns/100ps
module cwd_period_decode
  import cwd_pkg::*;
(
  // Period select code.
  input wire logic [4:0] code_in,
  // Divide exponent and software-control flag.
  output logic [4:0] exp_out,
  output logic runtime_ok_out
);

  // Linear codes add the offset; high codes other than 31 fall back to the shortest ratio.
  always_comb begin
    runtime_ok_out = 1'b0;
    if (code_in <= CWD_CODE_LAST_LINEAR) begin
      exp_out = 5'(code_in + CWD_EXP_OFFSET);
    end else if (code_in == CWD_CODE_DEFAULT) begin
      exp_out = 5'(CWD_CODE_DEFAULT_AS + CWD_EXP_OFFSET);
      runtime_ok_out = 1'b1;
    end else begin
      exp_out = CWD_EXP_OFFSET;
    end
  end

endmodule

// [rtl/cwd_pkg.sv]
package cwd_pkg;

  // Register byte offsets on the bus.
  localparam logic [7:0] CWD_WDT_WORD_OFS = 8'h00;
  localparam logic [7:0] CWD_MEM_WORD_OFS = 8'h04;
  localparam logic [7:0] CWD_RUNTIME_OFS = 8'h08;
  localparam logic [7:0] CWD_STATUS_OFS = 8'h0C;

  // Erased value of both words, and bits that always read as one.
  localparam logic [13:0] CWD_WORD_ERASED = 14'h3FFF;
  localparam logic [13:0] CWD_WDT_ONES = 14'h0080;
  localparam logic [13:0] CWD_MEM_ONES = 14'h1460;

  // Field positions in the watchdog word.
  localparam int CWD_PSEL_LSB = 0;

  // Field positions in the memory word.
  localparam int CWD_LV_PROG_BIT = 13;
  localparam int CWD_WRSAF_BIT = 11;
  localparam int CWD_WRCFG_BIT = 9;
  localparam int CWD_WRBOOT_BIT = 8;
  localparam int CWD_WRAPP_BIT = 7;
  localparam int CWD_STORE_EN_BIT = 4;
  localparam int CWD_BOOT_EN_BIT = 3;
  localparam int CWD_BOOT_SIZE_LSB = 0;

  // Period select codes and divide exponents.
  localparam logic [4:0] CWD_CODE_LAST_LINEAR = 5'h12;
  localparam logic [4:0] CWD_CODE_DEFAULT = 5'h1F;
  localparam logic [4:0] CWD_CODE_DEFAULT_AS = 5'h0B;
  localparam logic [4:0] CWD_EXP_OFFSET = 5'h05;
  localparam logic [4:0] CWD_RUNTIME_RESET = 5'h0B;

  // Boot region sizes in words.
  localparam logic [2:0] CWD_BOOT_CODE_SMALL = 3'h7;
  localparam logic [10:0] CWD_BOOT_SMALL = 11'h200;
  localparam logic [10:0] CWD_BOOT_HALF = 11'h400;

endpackage

// [testbench/cwd_config_decode_tb_top.sv]
`timescale 1ns/100ps
module cwd_config_decode_tb_top;
  import cwd_pkg::*;
  logic clk_in = 1'b0, reset_in = 1'b1, wb_req = 1'b0, wb_we = 1'b0;
  logic [7:0] wb_adr = 8'h00;
  logic [3:0] wb_sel = 4'hF, lanes = 4'hF;
  logic [31:0] wb_dat = 32'h0, wb_rdat;
  logic wb_ack, wallow, lv_ok, hv_req, p_app, p_store, p_boot, p_cfg, prog_on, lv_on;
  logic [13:0] nvw, nvm, ww, mw, nw;
  logic [4:0] wexp, rt, r;
  logic [10:0] bsz;
  logic [31:0] rd;
  logic [16:0] me;
  logic lv;
  int num_errors = 0, num_checks = 0;
  wire logic [16:0] mem_outs = {lv_ok, hv_req, p_app, p_store, p_boot, p_cfg, bsz};
  wire logic [5:0] wdt_outs = {wallow, wexp};
  localparam logic [13:0] CORNER [4] = '{14'h0007, 14'h0000, 14'h3FFF, 14'h2010};

  cwd_prog_model pm (.clk_in(clk_in), .nv_wdt_word_out(nvw), .nv_mem_word_out(nvm),
    .prog_active_out(prog_on), .lv_session_out(lv_on));
  cwd_config_decode dut (.clk_in(clk_in), .reset_in(reset_in), .nv_wdt_word_in(nvw),
    .nv_mem_word_in(nvm), .prog_active_in(prog_on), .lv_session_in(lv_on),
    .wb_cyc_in(wb_req), .wb_stb_in(wb_req), .wb_we_in(wb_we), .wb_adr_in(wb_adr),
    .wb_sel_in(wb_sel), .wb_dat_in(wb_dat), .wb_dat_out(wb_rdat), .wb_ack_out(wb_ack),
    .wdt_prescale_exp_out(wexp), .wdt_runtime_allowed_out(wallow),
    .lv_entry_allowed_out(lv_ok), .hv_required_out(hv_req), .app_protect_out(p_app),
    .storage_protect_out(p_store), .boot_protect_out(p_boot), .cfg_protect_out(p_cfg),
    .boot_size_out(bsz));

  // Free-running 20 MHz clock.
  always #25 clk_in = ~clk_in;

  // Divide exponent for a period code; unused top codes fall back to the shortest.
  function automatic logic [4:0] pexp(input logic [4:0] c);
    if (c == 5'h1F) return 5'h10;
    if (c > 5'h12) return 5'h05;
    return c + 5'h05;
  endfunction
  function automatic logic [5:0] wexp_f(input logic [4:0] c, input logic [4:0] rc);
    return (c == 5'h1F) ? {1'b1, pexp(rc)} : {1'b0, pexp(c)};
  endfunction
  function automatic logic [16:0] mexp_f(input logic [13:0] w);
    logic [10:0] s;
    s = w[3] ? 11'h000 : ((w[2:0] == 3'h7) ? 11'h200 : 11'h400);
    return {w[13], ~w[13], ~w[7], ~w[11] & ~w[4], ~w[8], ~w[9], s};
  endfunction

  // Compares one value and counts it.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One classic cycle; the wait is bounded so a dead slave cannot hang the run.
  task automatic wb_xfer(input logic we, input logic [7:0] adr, input logic [31:0] dat);
    int n;
    n = 0;
    @(posedge clk_in);
    wb_req <= 1'b1;
    wb_we <= we;
    wb_sel <= lanes;
    wb_adr <= adr;
    wb_dat <= dat;
    do begin
      @(posedge clk_in);
      n++;
    end while (wb_ack !== 1'b1 && n < 20);
    rd = wb_rdat;
    wb_req <= 1'b0;
    if (n >= 20) chk(32'h1, 32'h0);
  endtask
  // Decoded outputs trail the word flop by one edge.
  task automatic settle();
    repeat (3) @(posedge clk_in);
    #1;
  endtask
  task automatic close_out();
    $display("checks=%0d errors=%0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // Watchdog well beyond the fewer than a thousand cycles the tests need.
  initial begin
    #2000000;
    num_errors++;
    close_out();
  end

  // Main sequence: start-up sampling, code sweep, memory word, refusals.
  initial begin
    void'($urandom(32'h8170E3F1));
    pm.burn(14'($urandom), 14'($urandom) | 14'h2000);
    repeat (4) @(posedge clk_in);
    reset_in <= 1'b0;
    settle();
    rt = CWD_RUNTIME_RESET;
    mw = nvm | CWD_MEM_ONES;
    chk(32'(mem_outs), 32'(mexp_f(mw)));
    chk(32'(wdt_outs), 32'(wexp_f(nvw[4:0], rt)));
    pm.session(1'b1, 1'b0);
    for (int c = 0; c < 32; c++) begin
      ww = {9'($urandom), 5'(c)};
      wb_xfer(1'b1, CWD_WDT_WORD_OFS, {18'h0, ww});
      settle();
      chk(32'(wdt_outs), 32'(wexp_f(5'(c), rt)));
      r = 5'($urandom);
      wb_xfer(1'b1, CWD_RUNTIME_OFS, {27'h0, r});
      if (c == 31) rt = r;
      settle();
      chk(32'(wdt_outs), 32'(wexp_f(5'(c), rt)));
      wb_xfer(1'b0, CWD_STATUS_OFS, 32'h0);
      me = mexp_f(mw);
      chk(rd, {15'h0, me[10:0], wexp_f(5'(c), rt)});
      wb_xfer(1'b0, CWD_WDT_WORD_OFS, 32'h0);
      chk(rd, {18'h0, ww | CWD_WDT_ONES});
    end
    for (int i = 0; i < 24; i++) begin
      lv = (i < 4) ? ~i[0] : 1'($urandom);
      nw = ((i < 4) ? CORNER[i] : 14'($urandom)) | CWD_MEM_ONES;
      pm.session(1'b1, lv);
      wb_xfer(1'b1, CWD_MEM_WORD_OFS, {18'h0, nw});
      if (lv && !nw[13]) nw[13] = mw[13];
      mw = nw;
      settle();
      chk(32'(mem_outs), 32'(mexp_f(mw)));
      wb_xfer(1'b0, CWD_MEM_WORD_OFS, 32'h0);
      chk(rd, {18'h0, mw});
    end
    // Lane enables: a runtime write without lane 0 is dropped; a high-lane write keeps 7:0.
    lanes = 4'hE;
    wb_xfer(1'b1, CWD_RUNTIME_OFS, {27'h0, ~rt});
    settle();
    chk(32'(wdt_outs), 32'(wexp_f(ww[4:0], rt)));
    lanes = 4'h2;
    wb_xfer(1'b1, CWD_WDT_WORD_OFS, 32'h00002A55);
    ww[13:8] = 6'h2A;
    lanes = 4'hF;
    // Without a session both words ignore writes; an unmapped place reads zero.
    pm.session(1'b0, 1'b0);
    wb_xfer(1'b1, CWD_MEM_WORD_OFS, 32'h0);
    wb_xfer(1'b1, CWD_WDT_WORD_OFS, 32'h0);
    settle();
    chk(32'(mem_outs), 32'(mexp_f(mw)));
    wb_xfer(1'b0, CWD_WDT_WORD_OFS, 32'h0);
    chk(rd, {18'h0, ww | CWD_WDT_ONES});
    wb_xfer(1'b0, 8'h10, 32'h0);
    chk(rd, 32'h0);
    // A mid-run reset brings back the reset values, then the fused words load again.
    @(posedge clk_in);
    reset_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    #1;
    chk(32'({wdt_outs, mem_outs}), 32'({6'h05, 17'h10000}));
    @(posedge clk_in);
    reset_in <= 1'b0;
    settle();
    rt = CWD_RUNTIME_RESET;
    chk(32'(mem_outs), 32'(mexp_f(nvm | CWD_MEM_ONES)));
    chk(32'(wdt_outs), 32'(wexp_f(nvw[4:0], rt)));
    close_out();
  end
endmodule

// [testbench/cwd_prog_model.sv]
`timescale 1ns/100ps
module cwd_prog_model (
  // Clock.
  input wire logic clk_in,
  // Fused words and session levels.
  output logic [13:0] nv_wdt_word_out,
  output logic [13:0] nv_mem_word_out,
  output logic prog_active_out,
  output logic lv_session_out
);
  // An erased part with no session open.
  initial begin
    nv_wdt_word_out = 14'h3FFF;
    nv_mem_word_out = 14'h3FFF;
    prog_active_out = 1'b0;
    lv_session_out = 1'b0;
  end
  // Words are burnt while the block is still held in reset.
  task automatic burn(input logic [13:0] wdt, input logic [13:0] mem);
    @(posedge clk_in);
    nv_wdt_word_out <= wdt;
    nv_mem_word_out <= mem;
  endtask
  // The session level is held for the whole session, so it never drops out.
  task automatic session(input logic on, input logic lv);
    @(posedge clk_in);
    prog_active_out <= on;
    lv_session_out <= on & lv;
  endtask
endmodule
